// ==== core/scu_cfg.svh ====
`ifndef SCU_CFG_SVH
`define SCU_CFG_SVH

// ==========================================================
// register offsets
`define SCU_CTRL_OFF      12'h000
`define SCU_STATUS_OFF    12'h004
`define SCU_TX_OFF        12'h008
`define SCU_RX_OFF        12'h00C
`define SCU_CFG_BASE      12'h010
`define SCU_DIV_BASE      12'h020
`define SCU_REG_STRIDE    12'h004

// ==========================================================
// control register fields
`define SCU_CTRL_RSTN_BIT 0
`define SCU_CTRL_DIS_BIT  1
`define SCU_CTRL_SEL_LSB  2
`define SCU_CTRL_SEL_MSB  3

// ==========================================================
// status register fields
`define SCU_STAT_LVL_BIT  0
`define SCU_STAT_IRQ_BIT  1

// ==========================================================
// card config fields (layout matches scu_card_cfg_s)
`define SCU_CFG_MSB       9
`define SCU_CFG_ACT_BIT   9

// ==========================================================
// reset values
`define SCU_CTRL_RST      4'h0
`define SCU_CFG_RST       10'h000
`define SCU_DIV_RST       8'h0C
`define SCU_TX_RST        8'h00
`define SCU_RX_RST        8'h00

// ==========================================================
// prescaler terminal counts (count runs 0..N-1)
`define SCU_PSC31_LAST    5'h1E
`define SCU_PSC32_LAST    5'h1F

`endif

// ==== core/scu_pkg.sv ====
package scu_pkg;

   // ==========================================================
   // per-card configuration, bit 0 is the sync select
   typedef struct packed {
      logic       active;
      logic       prescaleSel;
      logic       uartClockDoubleSel;
      logic [2:0] cardClockDivider;
      logic       clockStopLevel;
      logic       clockStop;
      logic       manualClock;
      logic       syncSel;
   } scu_card_cfg_s;

   // ==========================================================
   // card served by the single uart
   typedef enum logic [1:0] {
      SCU_CARD_A,
      SCU_CARD_B,
      SCU_CARD_AUX
   } scu_card_e;

endpackage

// ==== core/scu_if.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// card clock generator link
interface scu_clk_if;
   logic [2:0] divider;
   logic       cardClk;
   logic       risePulse;
   logic       dblPulse;
   modport gen  (input divider, output cardClk, output risePulse, output dblPulse);
   modport user (output divider, input cardClk, input risePulse, input dblPulse);
endinterface

// ==========================================================
// etu generator link
interface scu_etu_if;
   logic       enable;
   logic       srcRise;
   logic       srcDbl;
   logic       dividerZero;
   logic       doubleSel;
   logic       prescaleSel;
   logic [7:0] reload;
   logic       etuTick;
   modport gen  (input enable, input srcRise, input srcDbl, input dividerZero,
                 input doubleSel, input prescaleSel, input reload, output etuTick);
   modport user (output enable, output srcRise, output srcDbl, output dividerZero,
                 output doubleSel, output prescaleSel, output reload, input etuTick);
endinterface

`default_nettype wire

// ==== core/scu_card_clk.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "scu_cfg.svh"

module scu_card_clk (
   input  wire logic clk,
   input  wire logic rst,
   scu_clk_if.gen    cif
);

   logic [7:0] cnt;
   logic [7:0] halfLast;
   logic       lvl;
   logic       rise;
   logic       dbl;

   // ==========================================================
   // half period of 2^divider system cycles
   always_comb begin
      halfLast = 8'((9'h001 << cif.divider) - 9'h001);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt  <= 8'h00;
         lvl  <= 1'b0;
         rise <= 1'b0;
         dbl  <= 1'b0;
      end else begin
         rise <= 1'b0;
         dbl  <= 1'b0;
         if (cnt >= halfLast) begin
            cnt  <= 8'h00;
            lvl  <= ~lvl;
            rise <= ~lvl;
            // doubled rate only exists off the fastest setting
            dbl  <= (cif.divider != 3'h0) ? 1'b1 : ~lvl;
         end else begin
            cnt <= cnt + 8'h01;
         end
      end
   end

   assign cif.cardClk   = lvl;
   assign cif.risePulse = rise;
   assign cif.dblPulse  = dbl;

endmodule

`default_nettype wire

// ==== core/scu_etu_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "scu_cfg.svh"

module scu_etu_gen #(
   parameter int DIV_W = 8
) (
   input  wire logic clk,
   input  wire logic rst,
   scu_etu_if.gen    eif
);

   logic             src;
   logic [4:0]       psCnt;
   logic [4:0]       psLast;
   logic             psTick;
   logic [DIV_W-1:0] downCnt;
   logic             tick;

   // ==========================================================
   // source select and prescaler
   always_comb begin
      src    = (eif.doubleSel && !eif.dividerZero) ? eif.srcDbl : eif.srcRise;
      psLast = eif.prescaleSel ? `SCU_PSC32_LAST : `SCU_PSC31_LAST;
      psTick = src && (psCnt == psLast);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         psCnt <= 5'h00;
      end else if (!eif.enable) begin
         psCnt <= 5'h00;
      end else if (src) begin
         psCnt <= psTick ? 5'h00 : psCnt + 5'h01;
      end
   end

   // ==========================================================
   // autoreload down counter, a reload of 0 acts as 1
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         downCnt <= '0;
         tick    <= 1'b0;
      end else if (!eif.enable) begin
         downCnt <= '0;
         tick    <= 1'b0;
      end else begin
         tick <= 1'b0;
         if (psTick) begin
            if (downCnt <= DIV_W'(1)) begin
               downCnt <= DIV_W'(eif.reload);
               tick    <= 1'b1;
            end else begin
               downCnt <= downCnt - DIV_W'(1);
            end
         end
      end
   end

   assign eif.etuTick = tick;

endmodule

`default_nettype wire

// ==== core/scu_top.sv ====
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "scu_cfg.svh"


module scu_top #(
   parameter int NCARD = 3,
   parameter int NCLK  = 2
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [11:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  wire logic [NCARD-1:0] cardIoIn,
   output logic      [NCARD-1:0] cardIoOut,
   output logic      [NCARD-1:0] cardIoOe,
   output logic      [NCLK-1:0]  cardClkPin,
   input  wire logic             auxIrqIn,
   output logic                  hostIrq,
   output logic                  uartRstOut,
   output logic      [7:0]       uartTxData,
   input  wire logic             uartTxBit,
   input  wire logic             uartTxEn,
   input  wire logic [7:0]       uartRxByte,
   input  wire logic             uartRxValid,
   output logic                  selIoIn,
   output logic                  etuTick
);

   // ==========================================================
   // declarations
   logic                 uartRstN;
   logic                 disAux;
   scu_pkg::scu_card_e   cardSel;
   logic [`SCU_CFG_MSB:0] cardCfgReg [NCARD];
   logic [7:0]           etuDiv [NCARD];
   logic [7:0]           txReg;
   logic [7:0]           rxReg;
   logic                 auxLvl;
   logic                 auxPrev;
   logic                 irqFlag;
   logic                 wrEn;
   logic                 rdEn;
   logic                 mapped;
   logic [31:0]          rdData;
   logic [NCARD-1:0]     cfgHit;
   logic [NCARD-1:0]     divHit;
   logic [NCARD-1:0]     actRise;
   logic                 selIo;
   scu_pkg::scu_card_cfg_s selCfg;
   logic [2:0]           clkRise;
   logic [2:0]           clkDbl;
   logic [2:0]           clkLvl;

   scu_etu_if eif ();

   // ==========================================================
   // address decode helper
   function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
      hit = (addr[11:2] == off[11:2]);
   endfunction

   function automatic logic [11:0] cardOff(input logic [11:0] base, input int idx);
      cardOff = base + 12'(idx * 4);
   endfunction

   // ==========================================================
   // apb slave, answer one cycle into the access phase
   always_comb begin
      wrEn = psel && penable && pready && pwrite;
      rdEn = psel && penable && !pready && !pwrite;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
      end
   end

   always_comb begin
      rdData = 32'h0000_0000;
      mapped = 1'b0;
      if (hit(paddr, `SCU_CTRL_OFF)) begin
         mapped = 1'b1;
         rdData[`SCU_CTRL_RSTN_BIT] = uartRstN;
         rdData[`SCU_CTRL_DIS_BIT]  = disAux;
         rdData[`SCU_CTRL_SEL_MSB:`SCU_CTRL_SEL_LSB] = cardSel;
      end else if (hit(paddr, `SCU_STATUS_OFF)) begin
         mapped = 1'b1;
         rdData[`SCU_STAT_LVL_BIT] = auxLvl;
         rdData[`SCU_STAT_IRQ_BIT] = irqFlag;
      end else if (hit(paddr, `SCU_TX_OFF)) begin
         mapped = 1'b1;
         rdData[7:0] = txReg;
      end else if (hit(paddr, `SCU_RX_OFF)) begin
         mapped = 1'b1;
         rdData[7:0] = rxReg;
      end
      for (int i = 0; i < NCARD; i++) begin
         if (cfgHit[i]) begin
            mapped = 1'b1;
            rdData[`SCU_CFG_MSB:0] = cardCfgReg[i];
         end
         if (divHit[i]) begin
            mapped = 1'b1;
            rdData[7:0] = etuDiv[i];
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         prdata  <= rdEn ? rdData : 32'h0000_0000;
         pslverr <= psel && penable && !pready && !mapped;
      end
   end

   // ==========================================================
   // control register and card selection
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         uartRstN <= 1'(`SCU_CTRL_RST >> `SCU_CTRL_RSTN_BIT);
         disAux   <= 1'b0;
         cardSel  <= scu_pkg::SCU_CARD_A;
      end else if (wrEn) begin
         if (hit(paddr, `SCU_CTRL_OFF)) begin
            uartRstN <= pwdata[`SCU_CTRL_RSTN_BIT];
            disAux   <= pwdata[`SCU_CTRL_DIS_BIT];
            cardSel  <= scu_pkg::scu_card_e'(pwdata[`SCU_CTRL_SEL_MSB:`SCU_CTRL_SEL_LSB]);
         end
         for (int i = 0; i < NCARD; i++) begin
            if (actRise[i]) begin
               cardSel <= scu_pkg::scu_card_e'(2'(i));
            end
         end
      end
   end

   // ==========================================================
   // per-card config and divider registers
   genvar g;
   generate
      for (g = 0; g < NCARD; g++) begin : gCard
         always_comb begin
            cfgHit[g]  = hit(paddr, cardOff(`SCU_CFG_BASE, g));
            divHit[g]  = hit(paddr, cardOff(`SCU_DIV_BASE, g));
            actRise[g] = cfgHit[g] && pwdata[`SCU_CFG_ACT_BIT] && !cardCfgReg[g][`SCU_CFG_ACT_BIT];
         end

         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               cardCfgReg[g] <= `SCU_CFG_RST;
               etuDiv[g]     <= `SCU_DIV_RST;
            end else if (wrEn) begin
               if (cfgHit[g]) begin
                  cardCfgReg[g] <= pwdata[`SCU_CFG_MSB:0];
               end
               if (divHit[g]) begin
                  etuDiv[g] <= pwdata[7:0];
               end
            end
         end
      end
   endgenerate

   // ==========================================================
   // card clock generators, one per interface
   generate
      for (g = 0; g < NCARD; g++) begin : gClk
         scu_clk_if cif ();
         scu_pkg::scu_card_cfg_s cfg;
         assign cfg         = scu_pkg::scu_card_cfg_s'(cardCfgReg[g]);
         assign cif.divider = cfg.cardClockDivider;
         assign clkRise[g]  = cif.risePulse;
         assign clkDbl[g]   = cif.dblPulse;
         assign clkLvl[g]   = cif.cardClk;

         scu_card_clk uClk (
            .clk (clk),
            .rst (rst),
            .cif (cif)
         );
      end
   endgenerate

   // ==========================================================
   // pin drivers; unselected lines float to the external pull-up
   generate
      for (g = 0; g < NCARD; g++) begin : gPin
         scu_pkg::scu_card_cfg_s cfg;
         logic                   mine;
         assign cfg  = scu_pkg::scu_card_cfg_s'(cardCfgReg[g]);
         assign mine = (cardSel == scu_pkg::scu_card_e'(2'(g)));

         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               cardIoOut[g] <= 1'b1;
               cardIoOe[g]  <= 1'b0;
            end else if (!mine || !cfg.active || !uartRstN) begin
               cardIoOut[g] <= 1'b1;
               cardIoOe[g]  <= 1'b0;
            end else if (cfg.syncSel) begin
               cardIoOut[g] <= txReg[0];
               cardIoOe[g]  <= 1'b1;
            end else begin
               cardIoOut[g] <= uartTxBit;
               cardIoOe[g]  <= uartTxEn;
            end
         end

         // aux has no clock pin, so its manual clock bit goes nowhere
         if (g < NCLK) begin : gClkPin
            always_ff @(posedge clk or posedge rst) begin
               if (rst) begin
                  cardClkPin[g] <= 1'b0;
               end else if (!cfg.active) begin
                  cardClkPin[g] <= 1'b0;
               end else if (cfg.syncSel) begin
                  cardClkPin[g] <= cfg.manualClock;
               end else if (cfg.clockStop) begin
                  cardClkPin[g] <= cfg.clockStopLevel;
               end else begin
                  cardClkPin[g] <= clkLvl[g];
               end
            end
         end
      end
   endgenerate

   // ==========================================================
   // uart data registers
   always_comb begin
      selCfg = scu_pkg::scu_card_cfg_s'(cardCfgReg[cardSel]);
      selIo  = cardIoIn[cardSel];
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         txReg <= `SCU_TX_RST;
      end else if (!uartRstN) begin
         txReg <= `SCU_TX_RST;
      end else if (wrEn && hit(paddr, `SCU_TX_OFF)) begin
         txReg <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rxReg <= `SCU_RX_RST;
      end else if (!uartRstN) begin
         rxReg <= `SCU_RX_RST;
      end else if (selCfg.syncSel) begin
         rxReg <= {7'h00, selIo};
      end else if (uartRxValid) begin
         rxReg <= uartRxByte;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         uartRstOut <= 1'b1;
         uartTxData <= 8'h00;
         selIoIn    <= 1'b1;
      end else begin
         uartRstOut <= ~uartRstN;
         uartTxData <= txReg;
         selIoIn    <= selIo;
      end
   end

   // ==========================================================
   // aux interrupt handshake; a new edge beats a clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         auxLvl  <= 1'b0;
         auxPrev <= 1'b0;
      end else begin
         auxLvl  <= auxIrqIn;
         auxPrev <= auxLvl;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irqFlag <= 1'b0;
      end else if ((auxLvl != auxPrev) && !disAux) begin
         irqFlag <= 1'b1;
      end else if (wrEn && hit(paddr, `SCU_STATUS_OFF) && pwdata[`SCU_STAT_IRQ_BIT]) begin
         irqFlag <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hostIrq <= 1'b0;
      end else begin
         hostIrq <= irqFlag;
      end
   end

   // ==========================================================
   // etu generation for the served card
   assign eif.enable      = uartRstN;
   assign eif.srcRise     = clkRise[cardSel];
   assign eif.srcDbl      = clkDbl[cardSel];
   assign eif.dividerZero = (selCfg.cardClockDivider == 3'h0);
   assign eif.doubleSel   = selCfg.uartClockDoubleSel;
   assign eif.prescaleSel = selCfg.prescaleSel;
   assign eif.reload      = etuDiv[cardSel];
   assign etuTick         = eif.etuTick;

   scu_etu_gen #(
      .DIV_W (8)
   ) uEtu (
      .clk (clk),
      .rst (rst),
      .eif (eif)
   );

endmodule

`default_nettype wire

// ==== bench/scu_props.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "scu_cfg.svh"

// ==========
// port checker
module scu_props #(
   parameter int NCARD = 3,
   parameter int NCLK  = 2
) (
   input wire logic             clk,
   input wire logic             rst,
   input wire logic             psel,
   input wire logic             penable,
   input wire logic             pwrite,
   input wire logic [11:0]      paddr,
   input wire logic [31:0]      prdata,
   input wire logic             pready,
   input wire logic             pslverr,
   input wire logic [NCARD-1:0] cardIoOe,
   input wire logic [NCLK-1:0]  cardClkPin,
   input wire logic             auxIrqIn,
   input wire logic             hostIrq,
   input wire logic             uartRstOut,
   input wire logic             etuTick
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   a_ready_timing: assert property (psel && penable && !pready |=> pready) else $error("pready late");
   a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
   a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata outside answer");
   a_uart_hold: assert property (uartRstOut && $past(uartRstOut) |-> !(|cardIoOe)) else $error("line driven");
   a_one_driver: assert property ($onehot0(cardIoOe)) else $error("two lines driven");
   a_irq_cause: assert property ($rose(hostIrq) |-> ($past(auxIrqIn, 2) != $past(auxIrqIn, 3))
      || ($past(auxIrqIn, 3) != $past(auxIrqIn, 4)) || ($past(auxIrqIn, 4) != $past(auxIrqIn, 5)))
      else $error("irq without aux change");
   a_irq_clear: assert property ($fell(hostIrq) |->
      $past(psel && penable && pready && pwrite && paddr == `SCU_STATUS_OFF, 2)
      || $past(psel && penable && pready && pwrite && paddr == `SCU_STATUS_OFF, 3))
      else $error("irq dropped without clear");
   a_tick_single: assert property (etuTick |=> !etuTick [*8]) else $error("etu ticks too close");
   // clock activity seen at least once
   c_clk_seen: cover property (cardClkPin != '0);
endmodule

bind scu_top scu_props #(.NCARD(NCARD), .NCLK(NCLK)) propsU (
   .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .cardIoOe(cardIoOe),
   .cardClkPin(cardClkPin), .auxIrqIn(auxIrqIn), .hostIrq(hostIrq), .uartRstOut(uartRstOut),
   .etuTick(etuTick));

`default_nettype wire

// ==== bench/scu_card_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========
// card side of the lines; released line pulled high, contention reads low
module scu_card_model #(
   parameter int NCARD = 3
) (
   input  wire logic [NCARD-1:0] cardIoOut,
   input  wire logic [NCARD-1:0] cardIoOe,
   input  wire logic [NCARD-1:0] cardDrive,
   input  wire logic [NCARD-1:0] cardVal,
   output logic      [NCARD-1:0] cardIoIn
);
   always_comb begin
      for (int i = 0; i < NCARD; i++) begin
         cardIoIn[i] = (cardIoOe[i] ? cardIoOut[i] : 1'b1) & (cardDrive[i] ? cardVal[i] : 1'b1);
      end
   end
endmodule

`default_nettype wire

// ==== bench/smartcard_uart_etu_mode_control_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "scu_cfg.svh"
`define CHK(nm, e, a) begin samplesChecked++; if ((a) !== (e)) begin failCount++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, e, a); end end

module smartcard_uart_etu_mode_control_test;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, auxIrqIn, hostIrq, uartRstOut;
   logic        uartTxBit, uartTxEn, uartRxValid, selIoIn, etuTick, err, ok;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0]  cardIoIn, cardIoOut, cardIoOe, cardDrive, cardVal;
   logic [1:0]  cardClkPin;
   logic [7:0]  uartTxData, uartRxByte, rb;
   int          failCount = 0, samplesChecked = 0, cycles = 0;
   int          tRl[4] = '{12, 16, 3, 0};
   bit          tDb[4] = '{0, 1, 1, 0};
   bit          tPs[4] = '{0, 1, 1, 0};

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   scu_top #(.NCARD(3), .NCLK(2)) dut_u (
      .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cardIoIn(cardIoIn),
      .cardIoOut(cardIoOut), .cardIoOe(cardIoOe), .cardClkPin(cardClkPin), .auxIrqIn(auxIrqIn),
      .hostIrq(hostIrq), .uartRstOut(uartRstOut), .uartTxData(uartTxData), .uartTxBit(uartTxBit),
      .uartTxEn(uartTxEn), .uartRxByte(uartRxByte), .uartRxValid(uartRxValid), .selIoIn(selIoIn),
      .etuTick(etuTick));

   scu_card_model #(.NCARD(3)) cardU (
      .cardIoOut(cardIoOut), .cardIoOe(cardIoOe), .cardDrive(cardDrive), .cardVal(cardVal),
      .cardIoIn(cardIoIn));

   // ==========
   // helpers
   task automatic completeRun();
      $display("comparisons %0d mismatches %0d", samplesChecked, failCount);
      if (failCount == 0 && samplesChecked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // worst case near 70k cycles; a hang lands here
   always @(posedge clk) begin
      cycles++;
      if (cycles == 100000) begin
         failCount++;
         completeRun();
      end
   end

   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdChk(input string nm, input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      `CHK(nm, e, rd)
   endtask

   // interval between two later ticks, so a stale count never matters
   task automatic etuMeasure(input int e);
      int n;
      repeat (2) begin
         @(posedge clk);
         while (etuTick !== 1'b1) @(posedge clk);
      end
      n = 1;
      @(posedge clk);
      while (etuTick !== 1'b1) begin
         n++;
         @(posedge clk);
      end
      `CHK("etu period", e, n)
   endtask

   function automatic logic [31:0] cfg(bit sy, bit man, bit stp, bit lvl, bit [2:0] dv, bit db, bit ps);
      return {22'h0, 1'b1, ps, db, dv, lvl, stp, man, sy};
   endfunction

   function automatic int etuExp(bit [2:0] dv, bit db, bit ps, int rl);
      return rl * (ps ? 32 : 31) * ((db && dv != 3'h0) ? 1 : 2) * (1 << dv);
   endfunction

   // ==========
   // main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata, uartTxEn, uartRxValid, uartRxByte, auxIrqIn} = '0;
      rst = 1'b1;
      uartTxBit = 1'b1;
      cardDrive = 3'h0;
      cardVal = 3'h7;
      void'($urandom(65));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      `CHK("uartRstOut", 1'b1, uartRstOut)
      rdChk("ctrl", `SCU_CTRL_OFF, 32'h0);
      rdChk("cfgA", `SCU_CFG_BASE, 32'h0);
      rdChk("divA", `SCU_DIV_BASE, 32'h0C);
      xfer(1'b1, 12'h100, 32'h5);
      `CHK("slverr", 1'b1, err)
      xfer(1'b1, `SCU_CTRL_OFF, 32'h1);
      repeat (2) @(posedge clk);
      `CHK("uartRstOut", 1'b0, uartRstOut)
      xfer(1'b1, `SCU_CFG_BASE, cfg(1, 0, 0, 0, 3'h3, 0, 0));
      xfer(1'b1, `SCU_TX_OFF, 32'h0);
      repeat (3) @(posedge clk);
      `CHK("oeA", 3'b001, cardIoOe)
      `CHK("outA", 1'b0, cardIoOut[0])
      rdChk("rxBit", `SCU_RX_OFF, 32'h0);
      for (int m = 1; m >= 0; m--) begin
         xfer(1'b1, `SCU_CFG_BASE, cfg(1, m[0], 0, 0, 3'h3, 0, 0));
         repeat (3) @(posedge clk);
         `CHK("manual clock", m[0], cardClkPin[0])
      end
      // aux takes the line; its manual clock reaches no pin
      xfer(1'b1, `SCU_TX_OFF, 32'h1);
      xfer(1'b1, `SCU_CFG_BASE + 12'h008, cfg(1, 1, 0, 0, 3'h3, 0, 0));
      repeat (3) @(posedge clk);
      `CHK("oe aux", 3'b100, cardIoOe)
      `CHK("lineA", 1'b1, cardIoIn[0])
      `CHK("aux out", 1'b1, cardIoOut[2])
      `CHK("clk pins", 2'h0, cardClkPin)
      `CHK("txData", 8'h01, uartTxData)
      // clearing the uart reset bit mid-run must free the line
      xfer(1'b1, `SCU_CTRL_OFF, 32'h0);
      repeat (3) @(posedge clk);
      `CHK("oe held", 3'b000, cardIoOe)
      `CHK("tx cleared", 8'h00, uartTxData)
      `CHK("uartRstOut", 1'b1, uartRstOut)
      xfer(1'b1, `SCU_CTRL_OFF, 32'h1);
      xfer(1'b1, `SCU_CFG_BASE, cfg(0, 0, 0, 0, 3'h3, 0, 0));
      uartTxEn <= 1'b1;
      uartTxBit <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK("oe async", 3'b001, cardIoOe)
      `CHK("out async", 1'b0, cardIoOut[0])
      uartTxEn <= 1'b0;
      cardDrive <= 3'b001;
      cardVal <= 3'b000;
      repeat (4) @(posedge clk);
      `CHK("oe rx", 3'b000, cardIoOe)
      `CHK("selIoIn", 1'b0, selIoIn)
      cardDrive <= 3'h0;
      rb = 8'($urandom);
      uartRxByte <= rb;
      uartRxValid <= 1'b1;
      @(posedge clk);
      uartRxValid <= 1'b0;
      rdChk("rx byte", `SCU_RX_OFF, {24'h0, rb});
      for (int l = 0; l < 2; l++) begin
         xfer(1'b1, `SCU_CFG_BASE, cfg(0, 0, 1, l[0], 3'h3, 0, 0));
         repeat (40) @(posedge clk);
         ok = 1'b1;
         repeat (32) begin
            @(posedge clk);
            if (cardClkPin[0] !== l[0]) ok = 1'b0;
         end
         `CHK("clock stop", 1'b1, ok)
      end
      // interrupt raised, cleared, then masked
      auxIrqIn <= 1'b1;
      repeat (5) @(posedge clk);
      `CHK("hostIrq", 1'b1, hostIrq)
      rdChk("status", `SCU_STATUS_OFF, 32'h3);
      xfer(1'b1, `SCU_STATUS_OFF, 32'h2);
      repeat (3) @(posedge clk);
      `CHK("irq clear", 1'b0, hostIrq)
      xfer(1'b1, `SCU_CTRL_OFF, 32'h3);
      auxIrqIn <= 1'b0;
      repeat (5) @(posedge clk);
      `CHK("irq masked", 1'b0, hostIrq)
      rdChk("status", `SCU_STATUS_OFF, 32'h0);
      // table rows 372/1 and 512/2 first, then the divider-zero doubler and reload-0 corners, then random reloads
      for (int i = 0; i < 7; i++) begin
         bit [2:0] dv;
         bit       db;
         bit       ps;
         int       rl;
         // divider 3 gives 3.125 MHz; zero only for the doubler corner
         dv = (i == 2) ? 3'h0 : 3'h3;
         db = (i < 4) ? tDb[i] : 1'($urandom % 2);
         ps = (i < 4) ? tPs[i] : 1'($urandom % 2);
         rl = (i < 4) ? tRl[i] : 1 + int'($urandom % 8);
         xfer(1'b1, `SCU_DIV_BASE, 32'(rl));
         xfer(1'b1, `SCU_CFG_BASE, cfg(0, 0, 0, 0, dv, db, ps));
         etuMeasure(etuExp(dv, db, ps, (rl == 0) ? 1 : rl));
      end
      completeRun();
   end
endmodule

`default_nettype wire
